// [core/host_port_pkg.sv]
// Shared types and constants of the dual-channel host bus port.
// Assumes one 20 MHz clock with every pin input already synchronous to it.
package host_port_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int REG_ADDR_W = 3;
    localparam int DATA_W = 8;

    // Strap level that selects strobe style; the other level selects direction style
    localparam logic STYLE_STROBE = 1'b1;
    localparam logic STYLE_RESET = STYLE_STROBE;

    // Direction line levels in direction style
    localparam logic DIR_READ = 1'b1;

    // Channel codes, also the level of the channel address bit
    localparam logic CHAN_A = 1'b0;
    localparam logic CHAN_B = 1'b1;

    // Reset values of the pin side
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [REG_ADDR_W-1:0] ADDR_RESET = 3'h0;
    localparam logic PIN_N_RESET = 1'b1;
    localparam logic IRQ_RESET = 1'b0;
    localparam logic OE_N_RESET = 1'b1;

    typedef enum logic [1:0] {
        PHASE_IDLE,
        PHASE_READ,
        PHASE_WRITE
    } phase_t;

    // Status that one channel's register file hands to the port
    typedef struct packed {
        logic irq;               // Channel interrupt pending, active high
        logic irq_output_enable; // Bit 3 of the channel's modem_control_reg
        logic tx_ready;          // tx_holding_reg / transmit FIFO can take data
        logic rx_ready;          // rx_holding_reg / receive FIFO holds data
    } chan_status_t;

    // One register access toward the channel register files
    typedef struct packed {
        logic rd;                        // One-cycle read pulse
        logic wr;                        // One-cycle write pulse
        logic chan;                      // CHAN_A or CHAN_B
        logic [REG_ADDR_W-1:0] addr;     // Register within the channel
        logic [DATA_W-1:0] wdata;        // Write byte
    } reg_req_t;

    localparam reg_req_t REQ_RESET = '{rd: 1'b0, wr: 1'b0, chan: CHAN_A, addr: ADDR_RESET, wdata: DATA_RESET};

endpackage

// [core/host_bus_port.sv]
// Host-side parallel bus port of a dual-channel UART: pin decode for both bus
// styles, register access requests, interrupt and ready status pins.
// Assumes register files outside that answer a read in the same cycle as the
// read pulse, and a board that resolves the data bus and interrupt pins from
// the output enables.
//
// Functional notes
// - Strobe style: read strobe low starts register read; byte driven on data bus.
// - Strobe style: write strobe falls to start, rising edge stores bus byte.
// - Direction style: former write strobe is direction, high read, low write.
// - Strobe style: separate active-low selects enable channel A and channel B.
// - Direction style: one chip select; channel B select becomes channel address bit.
// - Strobe style: channel A interrupt driven and out-port2 low when enable bit set.
// - Channel B interrupt and out-port2 follow its enable bit; cleared is default.
// - Direction style: channel A interrupt pin is shared active-low open-drain interrupt.
// - Each channel drives active-low transmitter-ready from its transmit status.
// - Each channel drives active-low receiver-ready from its receive status.
// - Three-bit register address selects a register of the addressed channel.
// - Eight-bit bidirectional data bus, driven by the device only during reads.
`timescale 1ns/100ps

module host_bus_port
    import host_port_pkg::*;
(
    input wire logic clk_i,                                // 20 MHz clock
    input wire logic sys_rst_i,                            // Async reset, active high
    input wire logic bus_style_i,                          // Strap, high = strobe style
    input wire logic read_strobe_n_i,                      // Read strobe, active low
    input wire logic write_strobe_n_i,                     // Write strobe or direction
    input wire logic chan_a_select_n_i,                    // Channel A or chip select
    input wire logic chan_b_select_n_i,                    // Channel B select or address bit
    input wire logic [REG_ADDR_W-1:0] register_address_i,  // Register address
    input wire logic [DATA_W-1:0] data_i,                  // Data bus level
    output logic [DATA_W-1:0] data_o,                      // Read byte
    output logic data_oe_n_o,                              // Low while driving data bus
    input wire logic [DATA_W-1:0] chan_a_rdata_i,          // Channel A read data
    input wire logic [DATA_W-1:0] chan_b_rdata_i,          // Channel B read data
    output reg_req_t reg_req_o,                            // Register access request
    input wire chan_status_t chan_a_status_i,              // Channel A status
    input wire chan_status_t chan_b_status_i,              // Channel B status
    output logic chan_a_irq_o,                             // Channel A interrupt level
    output logic chan_a_irq_oe_n_o,                        // Low while driving it
    output logic chan_b_irq_o,                             // Channel B interrupt level
    output logic chan_b_irq_oe_n_o,                        // Low while driving it
    output logic chan_a_out_port2_n_o,                     // Channel A output port 2
    output logic chan_b_out_port2_n_o,                     // Channel B output port 2
    output logic chan_a_tx_ready_n_o,                      // Channel A transmit ready
    output logic chan_a_rx_ready_n_o,                      // Channel A receive ready
    output logic chan_b_tx_ready_n_o,                      // Channel B transmit ready
    output logic chan_b_rx_ready_n_o                       // Channel B receive ready
);

    // Strap caught after reset release, so the async reset sees constants only
    logic strap_taken;
    logic bus_style;
    phase_t phase;
    phase_t next_phase;

    logic strobe_style;
    logic strobe_any_sel;
    logic strobe_chan;
    logic rd_now;
    logic wr_now;
    logic pin_chan;
    logic read_start;
    logic write_start;
    logic write_end;
    logic access_start;
    logic [DATA_W-1:0] rdata_sel;
    logic next_oe_n;
    logic any_irq;

    logic next_a_irq;
    logic next_a_irq_oe_n;

    assign strobe_style = (bus_style == STYLE_STROBE);

    // Channel A select wins if the host lowers both selects at once
    assign strobe_any_sel = !chan_a_select_n_i || !chan_b_select_n_i;
    assign strobe_chan = chan_a_select_n_i ? CHAN_B : CHAN_A;

    // Access decode, one rule for reads and writes in either style
    function automatic logic access_on(
        input logic style_is_strobe,
        input logic strobe_n,
        input logic any_sel,
        input logic chip_sel_n,
        input logic dir,
        input logic dir_wanted
    );
        logic on;
        if (style_is_strobe)
        begin
            on = !strobe_n && any_sel;
        end
        else
        begin
            on = !chip_sel_n && (dir == dir_wanted);
        end
        return on;
    endfunction

    // Read strobe takes no part in direction style
    assign rd_now = access_on(strobe_style, read_strobe_n_i, strobe_any_sel,
        chan_a_select_n_i, write_strobe_n_i, DIR_READ);
    assign wr_now = access_on(strobe_style, write_strobe_n_i, strobe_any_sel,
        chan_a_select_n_i, write_strobe_n_i, !DIR_READ);

    assign pin_chan = strobe_style ? strobe_chan : chan_b_select_n_i;

    assign read_start = (phase == PHASE_IDLE) && rd_now;
    assign write_start = (phase == PHASE_IDLE) && !rd_now && wr_now;
    assign access_start = read_start || write_start;

    // Write lands when the strobe or the chip select goes back high
    assign write_end = (phase == PHASE_WRITE) && !wr_now;

    always_comb
    begin
        next_phase = phase;
        unique case (phase)
            PHASE_IDLE:
            begin
                // Read wins when both strobes are low
                if (rd_now)
                begin
                    next_phase = PHASE_READ;
                end
                else if (wr_now)
                begin
                    next_phase = PHASE_WRITE;
                end
            end
            PHASE_READ:
            begin
                if (!rd_now)
                begin
                    next_phase = PHASE_IDLE;
                end
            end
            PHASE_WRITE:
            begin
                if (!wr_now)
                begin
                    next_phase = PHASE_IDLE;
                end
            end
        endcase
    end

    // Read byte is picked by the channel latched at the start of the access
    assign rdata_sel = (reg_req_o.chan == CHAN_B) ? chan_b_rdata_i : chan_a_rdata_i;

    // Drive only once the byte from the read pulse is in data_o
    assign next_oe_n = !((phase == PHASE_READ) && rd_now);

    // Strobe style: per channel enable; direction style: shared open drain
    assign any_irq = chan_a_status_i.irq || chan_b_status_i.irq;
    assign next_a_irq = strobe_style ? chan_a_status_i.irq : 1'b0;
    assign next_a_irq_oe_n = strobe_style
        ? !chan_a_status_i.irq_output_enable
        : !any_irq;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            strap_taken <= 1'b0;
            bus_style <= STYLE_RESET;
        end
        else if (!strap_taken)
        begin
            strap_taken <= 1'b1;
            bus_style <= bus_style_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            phase <= PHASE_IDLE;
        end
        else
        begin
            phase <= next_phase;
        end
    end

    // Address and channel held from the start so late pin changes do no harm
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            reg_req_o <= REQ_RESET;
        end
        else
        begin
            reg_req_o.rd <= read_start;
            reg_req_o.wr <= write_end;
            if (access_start)
            begin
                reg_req_o.chan <= pin_chan;
                reg_req_o.addr <= register_address_i;
            end
            // Last byte seen with the strobe low, so a short hold time still works
            if (wr_now && (write_start || phase == PHASE_WRITE))
            begin
                reg_req_o.wdata <= data_i;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            data_oe_n_o <= OE_N_RESET;
        end
        else
        begin
            data_oe_n_o <= next_oe_n;
        end
    end

    // Read byte kept until the next read, so a late host sample still sees it
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            data_o <= DATA_RESET;
        end
        else if (reg_req_o.rd)
        begin
            data_o <= rdata_sel;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            chan_a_irq_o <= IRQ_RESET;
            chan_a_irq_oe_n_o <= OE_N_RESET;
        end
        else
        begin
            // Direction style: value stays low, only the enable moves
            chan_a_irq_o <= next_a_irq;
            chan_a_irq_oe_n_o <= next_a_irq_oe_n;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            chan_b_irq_o <= IRQ_RESET;
            chan_b_irq_oe_n_o <= OE_N_RESET;
        end
        else
        begin
            chan_b_irq_o <= chan_b_status_i.irq;
            chan_b_irq_oe_n_o <= !chan_b_status_i.irq_output_enable;
        end
    end

    // Ready and out-port2 pins are alike in both channels
    chan_status_t status_by_chan [2];
    logic tx_ready_n [2];
    logic rx_ready_n [2];
    logic out_port2_n [2];

    assign status_by_chan[0] = chan_a_status_i;
    assign status_by_chan[1] = chan_b_status_i;

    // One flop per pin and channel; no gating, the pins follow status a cycle late
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan_pins
        always_ff @(posedge clk_i or posedge sys_rst_i)
        begin
            if (sys_rst_i)
            begin
                tx_ready_n[ch] <= PIN_N_RESET;
                rx_ready_n[ch] <= PIN_N_RESET;
                out_port2_n[ch] <= PIN_N_RESET;
            end
            else
            begin
                tx_ready_n[ch] <= !status_by_chan[ch].tx_ready;
                rx_ready_n[ch] <= !status_by_chan[ch].rx_ready;
                out_port2_n[ch] <= !status_by_chan[ch].irq_output_enable;
            end
        end
    end

    assign chan_a_tx_ready_n_o = tx_ready_n[0];
    assign chan_b_tx_ready_n_o = tx_ready_n[1];
    assign chan_a_rx_ready_n_o = rx_ready_n[0];
    assign chan_b_rx_ready_n_o = rx_ready_n[1];
    assign chan_a_out_port2_n_o = out_port2_n[0];
    assign chan_b_out_port2_n_o = out_port2_n[1];

endmodule

// [bench/host_port_properties.sv]
// Checker of the host bus port, bound to its top module ports.
// Assumes the style strap only changes while reset is held.
`timescale 1ns/100ps
module host_port_properties
    import host_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic bus_style_i,
    input wire logic [DATA_W-1:0] chan_a_rdata_i,
    input wire logic [DATA_W-1:0] chan_b_rdata_i,
    input wire logic [DATA_W-1:0] data_o,
    input wire logic data_oe_n_o,
    input wire reg_req_t reg_req_o,
    input wire chan_status_t chan_a_status_i,
    input wire chan_status_t chan_b_status_i,
    input wire logic chan_a_irq_o,
    input wire logic chan_a_irq_oe_n_o,
    input wire logic chan_b_irq_o,
    input wire logic chan_b_irq_oe_n_o,
    input wire logic chan_a_out_port2_n_o,
    input wire logic chan_b_out_port2_n_o,
    input wire logic chan_a_tx_ready_n_o,
    input wire logic chan_a_rx_ready_n_o,
    input wire logic chan_b_tx_ready_n_o,
    input wire logic chan_b_rx_ready_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [DATA_W-1:0] sel_rdata;
    assign sel_rdata = reg_req_o.chan ? chan_b_rdata_i : chan_a_rdata_i;

    property p_rd_pulse; reg_req_o.rd |=> !reg_req_o.rd; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse too long");
    property p_rd_data; reg_req_o.rd |=> !data_oe_n_o && data_o == $past(sel_rdata); endproperty
    a_rd_data: assert property (p_rd_data) else $error("read byte not driven");
    property p_wr_pulse; reg_req_o.wr |=> !reg_req_o.wr; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
    property p_oe_read; $fell(data_oe_n_o) |-> $past(reg_req_o.rd); endproperty
    a_oe_read: assert property (p_oe_read) else $error("bus driven outside read");
    // Skip the first edges after reset, where the strap is still being taken
    property p_tx_ready; !$past(sys_rst_i, 2) |-> {chan_a_tx_ready_n_o, chan_b_tx_ready_n_o}
        == ~$past({chan_a_status_i.tx_ready, chan_b_status_i.tx_ready}); endproperty
    a_tx_ready: assert property (p_tx_ready) else $error("tx ready pin wrong");
    property p_rx_ready; !$past(sys_rst_i, 2) |-> {chan_a_rx_ready_n_o, chan_b_rx_ready_n_o}
        == ~$past({chan_a_status_i.rx_ready, chan_b_status_i.rx_ready}); endproperty
    a_rx_ready: assert property (p_rx_ready) else $error("rx ready pin wrong");
    property p_port2; !$past(sys_rst_i, 2) |-> {chan_a_out_port2_n_o, chan_b_out_port2_n_o}
        == ~$past({chan_a_status_i.irq_output_enable, chan_b_status_i.irq_output_enable}); endproperty
    a_port2: assert property (p_port2) else $error("port2 pin wrong");
    property p_irq_b; !$past(sys_rst_i, 2) |-> chan_b_irq_oe_n_o == !$past(chan_b_status_i.irq_output_enable)
        && (chan_b_irq_oe_n_o || chan_b_irq_o == $past(chan_b_status_i.irq)); endproperty
    a_irq_b: assert property (p_irq_b) else $error("channel b irq wrong");
    property p_irq_a; bus_style_i && !$past(sys_rst_i, 2) |-> chan_a_irq_oe_n_o == !$past(chan_a_status_i.
        irq_output_enable) && (chan_a_irq_oe_n_o || chan_a_irq_o == $past(chan_a_status_i.irq)); endproperty
    a_irq_a: assert property (p_irq_a) else $error("channel a irq wrong");
    property p_irq_shared; !bus_style_i && !$past(sys_rst_i, 2) |-> !chan_a_irq_o
        && chan_a_irq_oe_n_o == !$past(chan_a_status_i.irq || chan_b_status_i.irq); endproperty
    a_irq_shared: assert property (p_irq_shared) else $error("shared irq wrong");
    c_read: cover property (reg_req_o.rd);
    c_write: cover property (reg_req_o.wr);
    c_shared: cover property (!bus_style_i && !chan_a_irq_oe_n_o);
endmodule

// [bench/reg_file_model.sv]
// Register file model of both channels, far side of the request port.
// Assumes read data is wanted in the cycle of the read pulse.
`timescale 1ns/100ps
module reg_file_model
    import host_port_pkg::*;
(
    input wire logic clk_i,                      // Port clock
    input wire reg_req_t req_i,                  // Request from the port
    output logic [DATA_W-1:0] chan_a_rdata_o,    // Channel A read byte
    output logic [DATA_W-1:0] chan_b_rdata_o     // Channel B read byte
);
    logic [DATA_W-1:0] mem [2][8];
    logic [DATA_W-1:0] word_a;
    logic [DATA_W-1:0] word_b;
    assign word_a = mem[0][req_i.addr];
    assign word_b = mem[1][req_i.addr];
    // Garbage outside the read cycle, so late sampling shows
    assign chan_a_rdata_o = req_i.rd ? word_a : ~word_a;
    assign chan_b_rdata_o = req_i.rd ? word_b : ~word_b;
    always_ff @(posedge clk_i)
    begin
        if (req_i.wr)
        begin
            mem[req_i.chan][req_i.addr] <= req_i.wdata;
        end
    end
endmodule

// [bench/testbench.sv]
// Self-checking bench of the host bus port in both bus styles.
// Assumes a register file model behind the request port.
`timescale 1ns/100ps
module testbench;
    import host_port_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic bus_style_i = STYLE_STROBE;
    logic read_strobe_n_i = 1'b1;
    logic write_strobe_n_i = 1'b1;
    logic chan_a_select_n_i = 1'b1;
    logic chan_b_select_n_i = 1'b1;
    logic [REG_ADDR_W-1:0] register_address_i = 3'h0;
    logic [DATA_W-1:0] host_data = 8'h00;
    logic [DATA_W-1:0] data_o;
    logic data_oe_n_o, chan_a_irq_o, chan_a_irq_oe_n_o, chan_b_irq_o, chan_b_irq_oe_n_o;
    logic chan_a_out_port2_n_o, chan_b_out_port2_n_o, chan_a_tx_ready_n_o, chan_a_rx_ready_n_o;
    logic chan_b_tx_ready_n_o, chan_b_rx_ready_n_o;
    chan_status_t chan_a_status_i = '0;
    chan_status_t chan_b_status_i = '0;
    reg_req_t reg_req_o;
    wire logic [DATA_W-1:0] chan_a_rdata_i;
    wire logic [DATA_W-1:0] chan_b_rdata_i;
    wire logic [DATA_W-1:0] data_i = data_oe_n_o ? host_data : data_o;
    int num_errors = 0;
    int checks_done = 0;
    always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    host_bus_port i_host_bus_port (.*);
    reg_file_model i_reg_file_model (.clk_i(clk_i), .req_i(reg_req_o), .chan_a_rdata_o(chan_a_rdata_i),
        .chan_b_rdata_o(chan_b_rdata_i));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic start(input logic style);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        bus_style_i <= style;
        read_strobe_n_i <= 1'b1;
        write_strobe_n_i <= 1'b1;
        chan_a_select_n_i <= 1'b1;
        chan_b_select_n_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic access(input logic wr, input logic ch, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        register_address_i <= a;
        host_data <= wr ? d : ~d;
        chan_a_select_n_i <= bus_style_i ? ch : 1'b0;
        chan_b_select_n_i <= bus_style_i ? !ch : ch;
        write_strobe_n_i <= !wr;
        if (bus_style_i)
            read_strobe_n_i <= wr;
        repeat (3) @(posedge clk_i);
        #1;
        if (!wr)
            check("read byte", {data_oe_n_o, d}, {1'b0, data_o});
        @(posedge clk_i);
        read_strobe_n_i <= 1'b1;
        chan_a_select_n_i <= 1'b1;
        if (bus_style_i)
        begin
            chan_b_select_n_i <= 1'b1;
            write_strobe_n_i <= 1'b1;
        end
        repeat (3) @(posedge clk_i);
        #1;
        check("bus released", 1'b1, data_oe_n_o);
    endtask

    task automatic test_rw(input logic [7:0] mask);
        logic [7:0] pat [4] = '{8'h3c, 8'hc3, 8'h81, 8'h18};
        for (int i = 0; i < 4; i++)
            access(1'b1, i[0], {3{i[1]}}, pat[i] ^ mask);
        for (int i = 0; i < 4; i++)
            access(1'b0, i[0], {3{i[1]}}, pat[i] ^ mask);
        $display("Test read write done, style %0d", bus_style_i);
    endtask

    // A write with no select must leave the register alone
    task automatic test_no_select(input logic [7:0] keep);
        @(posedge clk_i);
        host_data <= 8'h55;
        write_strobe_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        write_strobe_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        access(1'b0, CHAN_A, 3'h0, keep);
        $display("Test no select done, style %0d", bus_style_i);
    endtask

    task automatic test_status;
        logic [1:0] exp_a;
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk_i);
            chan_a_status_i <= i[3:0];
            chan_b_status_i <= ~i[3:0];
            repeat (2) @(posedge clk_i);
            #1;
            check("ready pins", {~{chan_a_status_i.tx_ready, chan_a_status_i.rx_ready, chan_b_status_i.tx_ready,
                chan_b_status_i.rx_ready}}, {chan_a_tx_ready_n_o, chan_a_rx_ready_n_o, chan_b_tx_ready_n_o,
                chan_b_rx_ready_n_o});
            check("port2 pins", {~{chan_a_status_i.irq_output_enable, chan_b_status_i.irq_output_enable}},
                {chan_a_out_port2_n_o, chan_b_out_port2_n_o});
            check("irq b", {!chan_b_status_i.irq_output_enable, chan_b_status_i.irq},
                {chan_b_irq_oe_n_o, chan_b_irq_oe_n_o ? chan_b_status_i.irq : chan_b_irq_o});
            exp_a = bus_style_i ? {!chan_a_status_i.irq_output_enable, chan_a_status_i.irq}
                : {!(chan_a_status_i.irq || chan_b_status_i.irq), 1'b0};
            check("irq a", exp_a, {chan_a_irq_oe_n_o, chan_a_irq_oe_n_o ? exp_a[0] : chan_a_irq_o});
        end
        $display("Test status done, style %0d", bus_style_i);
    endtask

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        start(STYLE_STROBE);
        test_rw(8'h00);
        test_no_select(8'h3c);
        test_status;
        start(~STYLE_STROBE);
        test_rw(8'hff);
        test_no_select(8'hc3);
        test_status;
        conclude;
    end

    initial
    begin
        repeat (4000) @(posedge clk_i);
        $display("Watchdog expired");
        num_errors++;
        conclude;
    end
endmodule

bind host_bus_port host_port_properties i_host_port_properties (.*);
